// *** hdl/llpcg_top.sv ***
// Line locked pixel clock generator with APB registers
`timescale 1ns/1ps
module llpcg_top #(
	parameter int DIV_WIDTH = 12
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [llpcg_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic line_sync_in,
	input wire logic green_sync_in,
	input wire logic coast_in,
	input wire logic vsync_in,
	input wire logic ext_clk_in,
	input wire logic vco_tick,
	output logic freq_up,
	output logic freq_down,
	output logic ref_edge,
	output logic [4:0] sog_level,
	output logic [1:0] oscillator_band_field,
	output logic [2:0] pump_current,
	output logic sample_clk,
	output logic shifted_line_sync_out,
	output logic coast_active,
	output logic sync_detect
);
	import llpcg_pkg::*;

	typedef struct packed {
		logic [DIV_WIDTH-1:0] div;
		logic [1:0] hpol;
		logic [1:0] cpol;
		logic [4:0] sog;
		logic [1:0] band;
		logic [2:0] pump;
		logic ext_clk;
		logic [4:0] phase;
		logic [DIV_WIDTH-1:0] cnt;
		logic ref_edge;
		logic line_d;
		logic green_d;
		logic up;
		logic down;
		logic seen_ref;
		logic seen_fb;
		logic coast;
		llpcg_lock_e lock;
		logic [31:0] rdata;
	} llpcg_s;

	// State after reset
	localparam llpcg_s ST_RST = '{
		div: DIV_WIDTH'(DIV_RST),
		hpol: POL_RST,
		cpol: POL_RST,
		sog: SOG_RST,
		band: BAND_RST,
		pump: PUMP_RST,
		ext_clk: 1'b0,
		phase: PHASE_RST,
		cnt: '0,
		ref_edge: 1'b0,
		line_d: 1'b0,
		green_d: 1'b0,
		up: 1'b0,
		down: 1'b0,
		seen_ref: 1'b0,
		seen_fb: 1'b0,
		coast: 1'b0,
		lock: LLPCG_ST_IDLE,
		rdata: '0
	};

	llpcg_s st_r;
	llpcg_s st_nxt;
	logic line_act;
	logic green_act;
	logic coast_act;
	logic src_tick;
	logic shifted_clk;
	logic shifted_line;
	logic wr_en;
	logic rd_en;
	logic [7:0] idx;
	logic hit;
	logic [DIV_WIDTH-1:0] div_last;
	logic wrap;
	logic line_rise;
	logic ext_coast;

	// ============================================================
	// Register index decode
	function automatic logic mapped(input logic [7:0] i);
		case (i)
			REG_DIV_HI_IDX,
			REG_DIV_LO_IDX,
			REG_HPOL_IDX,
			REG_CPOL_IDX,
			REG_SOG_IDX,
			REG_PLL_IDX,
			REG_PHASE_IDX,
			REG_STAT_IDX: begin
				mapped = 1'b1;
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
	endfunction

	// Polarity field bit 1 set means active high
	function automatic logic pol_apply(input logic sig, input logic [1:0] pol);
		pol_apply = pol[1] ? sig : ~sig;
	endfunction

	assign idx = paddr[9:2];
	assign hit = mapped(idx) && (paddr[1:0] == 2'h0);
	assign wr_en = psel && penable && pwrite && ce;
	assign rd_en = psel && !penable && !pwrite;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit;

	// ============================================================
	// Sync conditioning
	assign line_act = pol_apply(line_sync_in, st_r.hpol);
	assign green_act = ~green_sync_in;
	assign ext_coast = pol_apply(coast_in, st_r.cpol);
	assign coast_act = ext_coast || vsync_in;
	assign div_last = st_r.div - DIV_WIDTH'(1);
	assign wrap = src_tick && (st_r.cnt >= div_last);
	assign line_rise = (line_act || green_act) && !st_r.line_d;
	assign src_tick = st_r.ext_clk ? ext_clk_in : vco_tick;

	always_comb begin
		st_nxt = st_r;
		st_nxt.ref_edge = 1'b0;
		st_nxt.up = 1'b0;
		st_nxt.down = 1'b0;
		st_nxt.line_d = line_act || green_act;
		st_nxt.green_d = green_act;
		st_nxt.coast = coast_act;
		// ============================================================
		// Register writes
		if (wr_en && hit && pstrb[0]) begin
			unique case (idx)
				REG_DIV_HI_IDX: begin
					st_nxt.div[DIV_WIDTH-1:8] = pwdata[DIV_WIDTH-9:0];
				end
				REG_DIV_LO_IDX: begin
					st_nxt.div[7:0] = pwdata[7:0];
				end
				REG_HPOL_IDX: begin
					st_nxt.hpol = pwdata[HPOL_LSB+:2];
				end
				REG_CPOL_IDX: begin
					st_nxt.cpol = pwdata[CPOL_LSB+:2];
				end
				REG_SOG_IDX: begin
					st_nxt.sog = pwdata[SOG_LSB+:5];
				end
				REG_PLL_IDX: begin
					st_nxt.band = pwdata[PLL_BAND_LSB+:2];
					st_nxt.pump = pwdata[PLL_PUMP_LSB+:3];
					st_nxt.ext_clk = pwdata[PLL_EXTCLK_BIT];
				end
				REG_PHASE_IDX: begin
					st_nxt.phase = pwdata[PHASE_LSB+:5];
				end
				default: begin
				end
			endcase
		end
		// Divisors below two are clamped to two
		if (st_nxt.div < DIV_WIDTH'(DIV_MIN)) begin
			st_nxt.div = DIV_WIDTH'(DIV_MIN);
		end
		// ============================================================
		// Feedback divider, one edge per wrap
		if (src_tick) begin
			if (wrap) begin
				st_nxt.cnt = '0;
				st_nxt.ref_edge = 1'b1;
			end else begin
				st_nxt.cnt = st_r.cnt + DIV_WIDTH'(1);
			end
		end
		// ============================================================
		// Phase compare, held while coasting
		unique case (st_r.lock)
			LLPCG_ST_IDLE: begin
				st_nxt.seen_ref = 1'b0;
				st_nxt.seen_fb = 1'b0;
				if (!coast_act) begin
					st_nxt.lock = LLPCG_ST_TRACK;
				end
			end
			LLPCG_ST_TRACK: begin
				if (coast_act) begin
					st_nxt.lock = LLPCG_ST_COAST;
				end else begin
					if (line_rise) begin
						st_nxt.seen_ref = 1'b1;
					end
					if (st_nxt.ref_edge) begin
						st_nxt.seen_fb = 1'b1;
					end
					if (st_nxt.seen_ref && !st_nxt.seen_fb) begin
						st_nxt.up = 1'b1;
					end else if (st_nxt.seen_fb && !st_nxt.seen_ref) begin
						st_nxt.down = 1'b1;
					end else if (st_nxt.seen_fb && st_nxt.seen_ref) begin
						st_nxt.seen_ref = 1'b0;
						st_nxt.seen_fb = 1'b0;
					end
				end
			end
			LLPCG_ST_COAST: begin
				if (!coast_act) begin
					st_nxt.lock = LLPCG_ST_IDLE;
				end
			end
			default: begin
				st_nxt.lock = LLPCG_ST_IDLE;
			end
		endcase
		// ============================================================
		// Read data
		if (rd_en) begin
			st_nxt.rdata = '0;
			unique case (idx)
				REG_DIV_HI_IDX: begin
					st_nxt.rdata[DIV_WIDTH-9:0] = st_r.div[DIV_WIDTH-1:8];
				end
				REG_DIV_LO_IDX: begin
					st_nxt.rdata[7:0] = st_r.div[7:0];
				end
				REG_HPOL_IDX: begin
					st_nxt.rdata[HPOL_LSB+:2] = st_r.hpol;
				end
				REG_CPOL_IDX: begin
					st_nxt.rdata[CPOL_LSB+:2] = st_r.cpol;
				end
				REG_SOG_IDX: begin
					st_nxt.rdata[SOG_LSB+:5] = st_r.sog;
				end
				REG_PLL_IDX: begin
					st_nxt.rdata[7:0] = {st_r.band, st_r.pump, 2'h0, st_r.ext_clk};
				end
				REG_PHASE_IDX: begin
					st_nxt.rdata[PHASE_LSB+:5] = st_r.phase;
				end
				REG_STAT_IDX: begin
					st_nxt.rdata[3:0] = {st_r.green_d, st_r.line_d, st_r.coast,
						st_r.lock == LLPCG_ST_TRACK};
				end
				default: begin
					st_nxt.rdata = '0;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= ST_RST;
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	// ============================================================
	// Shared phase shift for clock and line sync
	llpcg_phase_shift #(
		.STEPS(PHASE_STEPS)
	) u_shift (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.phase(st_r.phase),
		.clk_tick(src_tick),
		.line_in(st_r.line_d),
		.clk_out(shifted_clk),
		.line_out(shifted_line)
	);

	assign prdata = st_r.rdata;
	assign freq_up = st_r.up;
	assign freq_down = st_r.down;
	assign ref_edge = st_r.ref_edge;
	assign sog_level = st_r.sog;
	assign oscillator_band_field = st_r.band;
	assign pump_current = st_r.pump;
	assign sample_clk = shifted_clk;
	assign shifted_line_sync_out = shifted_line;
	assign coast_active = st_r.coast;
	assign sync_detect = st_r.line_d;
endmodule

// *** pkg/llpcg_pkg.sv ***
// Package of constants for the line locked pixel clock generator
// Summary of operation
// - Green sync sliced against 5-bit trigger level, nominally 128 mV above baseline.
// - Green embedded sync is always negative-going; no polarity choice.
// - Pixel clock divided by divisor, phase-compared with line sync, frequency corrected.
// - Feedback divisor is 12 bits, legal 2 through 4095, sets multiplication.
// - 2-bit band select picks one of four overlapping oscillator ranges.
// - 3-bit pump select maps to 50 through 1500 microamperes.
// - 5-bit phase shifts sampling clock in 32 steps of 11.25 degrees.
// - Line sync output carries the same phase shift as sampling clock.
// - Phase shift still applies when external pixel clock is selected.
// - Coast, external or internal, holds frequency and ignores line sync.
// - Coast polarity lives in bits 6:5 of its control register.
// - Line sync polarity lives in bits 5:4 of its control register.
// - Polarity field bit 1 set means active high for line sync and coast.
// - Internal coast is derived from the vertical sync interval.
package llpcg_pkg;
	// ============================================================
	// Register indices; byte address is four times the index
	localparam logic [7:0] REG_DIV_HI_IDX = 8'h01;
	localparam logic [7:0] REG_DIV_LO_IDX = 8'h02;
	localparam logic [7:0] REG_HPOL_IDX = 8'h12;
	localparam logic [7:0] REG_CPOL_IDX = 8'h18;
	localparam logic [7:0] REG_SOG_IDX = 8'h1d;
	localparam logic [7:0] REG_PLL_IDX = 8'h03;
	localparam logic [7:0] REG_PHASE_IDX = 8'h04;
	localparam logic [7:0] REG_STAT_IDX = 8'h30;
	localparam int ADDR_W = 10;
	// ============================================================
	// Field positions
	localparam int DIV_W = 12;
	localparam int SOG_LSB = 3;
	localparam int HPOL_LSB = 4;
	localparam int CPOL_LSB = 5;
	localparam int PLL_BAND_LSB = 6;
	localparam int PLL_PUMP_LSB = 3;
	localparam int PLL_EXTCLK_BIT = 0;
	localparam int PHASE_LSB = 3;
	// ============================================================
	// Reset values and minimum divisor
	localparam logic [11:0] DIV_RST = 12'h320;
	localparam logic [1:0] BAND_RST = 2'h1;
	localparam logic [2:0] PUMP_RST = 3'h4;
	localparam logic [4:0] SOG_RST = 5'h10;
	localparam logic [1:0] POL_RST = 2'h2;
	localparam logic [4:0] PHASE_RST = 5'h00;
	localparam logic [11:0] DIV_MIN = 12'h002;
	// ============================================================
	// Analog reference figures, timing and lock states
	localparam int SOG_NOM_MV = 128;
	localparam int PHASE_STEPS = 32;
	localparam int PHASE_STEP_CDEG = 1125;
	localparam int CLK_NS = 100;
	localparam int VSYNC_COAST_NS = 100;
	localparam int VSYNC_COAST_CYC = (VSYNC_COAST_NS + CLK_NS - 1) / CLK_NS;
	typedef enum logic [1:0] {LLPCG_ST_IDLE, LLPCG_ST_TRACK, LLPCG_ST_COAST} llpcg_lock_e;
endpackage

// *** hdl/llpcg_phase_shift.sv ***
// Phase shifter applying one setting to sampling clock and line sync
`timescale 1ns/1ps
module llpcg_phase_shift #(
	parameter int STEPS = 32
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic [4:0] phase,
	input wire logic clk_tick,
	input wire logic line_in,
	output logic clk_out,
	output logic line_out
);
	import llpcg_pkg::*;
	typedef struct packed {
		logic [STEPS-1:0] clk_tap;
		logic [STEPS-1:0] line_tap;
	} llpcg_ps_s;
	llpcg_ps_s st_r;
	llpcg_ps_s st_nxt;
	// ============================================================
	// Clock and line tap lines, shifted together
	always_comb begin
		st_nxt = st_r;
		st_nxt.clk_tap = {st_r.clk_tap[STEPS-2:0], clk_tick};
		st_nxt.line_tap = {st_r.line_tap[STEPS-2:0], line_in};
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end
	assign clk_out = st_r.clk_tap[phase];
	assign line_out = st_r.line_tap[phase];
endmodule

// *** verification/llpcg_assertions.sv ***
// Port checker for the pixel clock generator
`timescale 1ns/1ps
module llpcg_assertions #(
	parameter int DIV_WIDTH = 12
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [llpcg_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic pslverr,
	input wire logic vsync_in,
	input wire logic freq_up,
	input wire logic freq_down,
	input wire logic ref_edge,
	input wire logic coast_active,
	input wire logic [4:0] sog_level,
	input wire logic [1:0] oscillator_band_field,
	input wire logic [2:0] pump_current
);
	import llpcg_pkg::*;
	wire logic wr;
	assign wr = psel && penable && pwrite && ce && pstrb[0];
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ============================================================
	// Assertions
	a_band_write: assert property (wr && paddr == 10'h00c |=> oscillator_band_field == $past(pwdata[7:6]))
		else $error("band field not loaded");
	a_sog_write: assert property (wr && paddr == 10'h074 |=> sog_level == $past(pwdata[7:3]))
		else $error("trigger level not loaded");
	a_pump_hold: assert property (!wr |=> $stable(pump_current))
		else $error("pump code changed without write");
	a_cfg_hold: assert property (!wr |=> $stable({oscillator_band_field, sog_level}))
		else $error("setting changed without write");
	a_ref_pulse: assert property (ce && ref_edge |=> !ref_edge)
		else $error("compare edge longer than one cycle");
	a_coast_vsync: assert property (ce && vsync_in |=> coast_active)
		else $error("vertical interval gave no coast");
	a_coast_freeze: assert property (coast_active && $past(coast_active) |-> !(freq_up || freq_down))
		else $error("correction during coast");
	a_freq_excl: assert property (!(freq_up && freq_down))
		else $error("both corrections at once");
	c_ref: cover property (ref_edge);
	c_coast: cover property (coast_active);
	c_err: cover property (pslverr);
	c_down: cover property (freq_down);
endmodule
bind llpcg_top llpcg_assertions #(.DIV_WIDTH(DIV_WIDTH)) chk_u (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
	.paddr, .pwdata, .pstrb, .pslverr, .vsync_in, .freq_up, .freq_down, .ref_edge, .coast_active, .sog_level,
	.oscillator_band_field, .pump_current);

// *** verification/llpcg_video_src.sv ***
// Video source model giving line sync and oscillator ticks
`timescale 1ns/1ps
module llpcg_video_src #(
	parameter int LINE = 1600
) (
	input wire logic pclk,
	input wire logic run,
	output logic vco_tick = 1'h0,
	output logic line_sync_in = 1'h0
);
	int cnt = 0;
	// Line period matches divisor 800 at one tick per two cycles; idle source stands still
	always @(posedge pclk) begin
		cnt <= run ? (cnt + 1) % LINE : 0;
		vco_tick <= run && cnt[0];
		line_sync_in <= run && cnt == 0;
	end
endmodule

// *** verification/llpcg_top_tb_top.sv ***
// Self-checking bench for the pixel clock generator
`timescale 1ns/1ps
module llpcg_top_tb_top;
	import llpcg_pkg::*;
	typedef struct {logic [9:0] a; logic [31:0] d; logic [31:0] m;} llpcg_row_s;
	logic pclk = 1'h0, presetn = 1'h0, ce = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, run = 1'h0;
	logic green_sync_in = 1'h1, coast_in = 1'h0, vsync_in = 1'h0, ext_clk_in = 1'h0;
	logic [9:0] paddr = 10'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd_q;
	logic [3:0] pstrb = 4'hf;
	logic pready, pslverr, err_q, line_sync_in, vco_tick, freq_up, freq_down, ref_edge, sample_clk;
	logic shifted_line_sync_out, coast_active, sync_detect;
	logic [4:0] sog_level;
	logic [1:0] oscillator_band_field;
	logic [2:0] pump_current;
	int error_cnt = 0, check_count = 0, n = 0, seen_c = 0, seen_l = 0;
	llpcg_row_s rows[7] = '{'{10'h00c, 32'ha0, 32'hf8}, '{10'h074, 32'h58, 32'hf8}, '{10'h048, 32'h20, 32'h30},
		'{10'h060, 32'h40, 32'h60}, '{10'h010, 32'hf8, 32'hf8}, '{10'h004, 32'h03, 32'h0f}, '{10'h008, 32'h20, 32'hff}};
	llpcg_top dut_u (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
		.pslverr, .line_sync_in, .green_sync_in, .coast_in, .vsync_in, .ext_clk_in, .vco_tick, .freq_up, .freq_down,
		.ref_edge, .sog_level, .oscillator_band_field, .pump_current, .sample_clk, .shifted_line_sync_out,
		.coast_active, .sync_detect);
	llpcg_video_src src_u (.pclk, .run, .vco_tick, .line_sync_in);
	// ============================================================
	// Tasks
	task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd_q = prdata;
		err_q = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		#1;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic settle();
		repeat (3) @(posedge pclk);
		#1;
	endtask
	// One-cycle pulse on the external tick and/or the green sync (low = sync)
	task automatic strobe(input logic clk_p, input logic grn_p);
		@(posedge pclk);
		ext_clk_in <= clk_p;
		green_sync_in <= !grn_p;
		@(posedge pclk);
		ext_clk_in <= 1'h0;
		green_sync_in <= 1'h1;
	endtask
	task automatic finish_test();
		if (error_cnt == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// ============================================================
	// Clock, watchdog and tests
	initial begin
		forever #50 pclk = ~pclk;
	end
	initial begin
		#5000000;
		error_cnt++;
		finish_test();
	end
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'h1;
		#1;
		chk(sog_level, SOG_RST);
		chk(oscillator_band_field, BAND_RST);
		chk(pump_current, PUMP_RST);
		foreach (rows[i]) begin
			apb(1'h1, rows[i].a, rows[i].d);
			apb(1'h0, rows[i].a, 32'h0);
			chk(rd_q & rows[i].m, rows[i].d & rows[i].m);
		end
		for (int i = 0; i < 8; i++) begin
			apb(1'h1, 10'h00c, {24'h0, i[1:0], i[2:0], 3'h0});
			chk(oscillator_band_field, i[1:0]);
			chk(pump_current, i[2:0]);
		end
		apb(1'h0, 10'h3fc, 32'h0);
		chk(err_q, 1'h1);
		chk(rd_q, 32'h0);
		apb(1'h1, 10'h004, 32'h0);
		apb(1'h1, 10'h008, 32'h1);
		apb(1'h0, 10'h008, 32'h0);
		chk(rd_q & 32'hff, 32'h02);
		@(posedge pclk) run <= 1'h1;
		repeat (400) begin
			@(posedge pclk);
			#1 n += ref_edge;
		end
		chk(n >= 98 && n <= 102, 1'h1);
		apb(1'h1, 10'h004, 32'h3);
		apb(1'h1, 10'h008, 32'h20);
		@(posedge pclk) vsync_in <= 1'h1;
		settle();
		chk(coast_active, 1'h1);
		@(posedge pclk) vsync_in <= 1'h0;
		for (int k = 0; k < 4; k++) begin
			apb(1'h1, 10'h060, {25'h0, k[1], 6'h0});
			@(posedge pclk) coast_in <= k[0];
			settle();
			chk(coast_active, k[1] == k[0]);
		end
		@(posedge pclk) run <= 1'h0;
		for (int k = 0; k < 2; k++) begin
			apb(1'h1, 10'h048, {26'h0, k[0], 5'h0});
			settle();
			chk(sync_detect, !k[0]);
		end
		apb(1'h1, 10'h00c, 32'h61);
		for (int p = 0; p < 32; p += 13) begin
			apb(1'h1, 10'h010, p << 3);
			repeat (40) @(posedge pclk);
			strobe(1'h1, 1'h1);
			seen_c = 0;
			seen_l = 0;
			for (int j = 1; j < 40; j++) begin
				#1;
				if (j == 1) begin
					chk(sync_detect, 1'h1);
				end
				if (sample_clk === 1'h1 && seen_c == 0) begin
					seen_c = j;
				end
				if (shifted_line_sync_out === 1'h1 && seen_l == 0) begin
					seen_l = j;
				end
				@(posedge pclk);
			end
			chk(seen_c, p + 1);
			chk(seen_l, p + 2);
		end
		@(posedge pclk) coast_in <= 1'h0;
		apb(1'h1, 10'h004, 32'h0);
		apb(1'h1, 10'h008, 32'h2);
		settle();
		repeat (2) strobe(1'h1, 1'h0);
		settle();
		chk(freq_down, 1'h1);
		chk(freq_up, 1'h0);
		strobe(1'h0, 1'h1);
		settle();
		chk({freq_up, freq_down}, 2'h0);
		strobe(1'h0, 1'h1);
		settle();
		chk({freq_up, freq_down}, 2'h2);
		@(posedge pclk) coast_in <= 1'h1;
		settle();
		chk(freq_up, 1'h0);
		@(posedge pclk) ce <= 1'h0;
		apb(1'h1, 10'h00c, 32'h0);
		@(posedge pclk) ce <= 1'h1;
		#1;
		chk(oscillator_band_field, 2'h1);
		finish_test();
	end
endmodule
